/* File: logic/pcseq_pkg.sv */
// Package of constants and types for the program counter sequencer.
package pcseq_pkg;

  // ****************************************************************
  // Widths and sizes.
  // ****************************************************************
  localparam int PC_W = 14;              // Counter width.
  localparam int INSTR_W = 16;           // Program word width.
  localparam int ADDR_FIELD_W = 13;      // Address field of jump and call.
  localparam int STACK_DEPTH = 16;       // Return stack levels.
  localparam int STACK_PTR_W = 4;        // Stack index width.
  localparam int BANK_SEL_POS = 5;       // Bank select bit within the bank pointer.

  // ****************************************************************
  // Timing and reset values.
  // ****************************************************************
  localparam int PHASE_COUNT = 4;        // System clocks per instruction cycle.
  localparam int STARTUP_PERIODS = 1024; // Start-up delay in system clock periods.
  localparam logic [13:0] PC_RESET = 14'h0000;   // Counter after reset.
  localparam logic [1:0] PHASE_RESET = 2'h0;     // Phase after reset.
  localparam logic [1:0] PHASE_LAST = 2'h3;      // Phase where the counter steps.
  localparam logic [10:0] STARTUP_RESET = 11'h000; // Start-up count after reset.

  // ****************************************************************
  // Interrupt vectors, bank 0 only.
  // ****************************************************************
  localparam logic [13:0] VEC_EXT0 = 14'h0004;   // External source 0.
  localparam logic [13:0] VEC_EXT1 = 14'h0008;   // External source 1.
  localparam logic [13:0] VEC_TMR0 = 14'h000c;   // Timer 0.
  localparam logic [13:0] VEC_TMR1 = 14'h0010;   // Timer 1.
  localparam logic [13:0] VEC_UART = 14'h0014;   // Serial port.
  localparam logic [13:0] VEC_MULTI = 14'h0018;  // Multi-function source.

  // Interrupt source selector as decoded by the core.
  typedef enum logic [2:0] {
    PCSEQ_IRQ_EXT0 = 3'h0,
    PCSEQ_IRQ_EXT1 = 3'h1,
    PCSEQ_IRQ_TMR0 = 3'h2,
    PCSEQ_IRQ_TMR1 = 3'h3,
    PCSEQ_IRQ_UART = 3'h4,
    PCSEQ_IRQ_MULTI = 3'h5
  } pcseq_irq_t;

  // Sequencer states, one-hot.
  typedef enum logic [2:0] {
    PCSEQ_ST_START = 3'b001,   // Start-up delay running.
    PCSEQ_ST_FILL = 3'b010,    // First fetch, nothing to execute yet.
    PCSEQ_ST_RUN = 3'b100      // Steady fetch and execute.
  } pcseq_state_t;

endpackage : pcseq_pkg

/* File: logic/pcseq_top.sv */
// Program counter sequencer: phases, pipeline, counter, stack and start-up delay.

// Behaviour
// - Four system clocks per instruction cycle.
// - Fetch next while executing previous instruction.
// - Counter changes cost an idle cycle.
// - Counter is fourteen bits wide.
// - Counter increments after each fetch.
// - Reset clears counter, starts at zero.
// - Interrupts load fixed vectors.
// - True skip discards fetched instruction.
// - Low byte write jumps within page.
// - Low byte reads current counter bits.
// - Jump takes field plus bank bit.
// - Bank bit selects lower or upper bank.
// - Returns restore all bits from stack.
// - Start-up delay of 1024 clock periods.
// - Sixteen-level stack pushed by calls, interrupts.
module pcseq_top #(
  parameter int STARTUP_CYCLES = pcseq_pkg::STARTUP_PERIODS
) (
  input wire logic CLOCK,
  input wire logic SRST,
  input wire logic WAKE_UP,
  input wire logic [pcseq_pkg::INSTR_W-1:0] FETCH_DATA,
  input wire logic EXEC_JUMP,
  input wire logic EXEC_CALL,
  input wire logic EXEC_RETURN,
  input wire logic EXEC_SKIP,
  input wire logic EXEC_LOW_WRITE,
  input wire logic [7:0] LOW_WRITE_DATA,
  input wire logic [pcseq_pkg::ADDR_FIELD_W-1:0] JUMP_ADDR,
  input wire logic [7:0] BANK_POINTER,
  input wire logic IRQ_ACCEPT,
  input wire pcseq_pkg::pcseq_irq_t IRQ_SOURCE,
  output logic [pcseq_pkg::PC_W-1:0] PROG_ADDR,
  output logic UPPER_PROGRAM_BANK,
  output logic [1:0] PHASE,
  output logic CYCLE_END,
  output logic [pcseq_pkg::INSTR_W-1:0] EXEC_WORD,
  output logic EXEC_VALID,
  output logic RUNNING,
  output logic [7:0] COUNTER_LOW_BYTE,
  output logic STACK_FULL
);
  import pcseq_pkg::*;

  // ****************************************************************
  // Declarations.
  // ****************************************************************
  pcseq_state_t state_reg;                // Sequencer state.
  logic [1:0] phase_reg;                  // Phase within the instruction cycle.
  logic [10:0] startup_reg;               // Start-up delay count.
  logic [PC_W-1:0] pc_reg;                // Program counter.
  logic [PC_W-1:0] pc_next;               // Next counter value.
  logic [INSTR_W-1:0] exec_reg;           // Instruction held for execution.
  logic exec_valid_reg;                   // Held instruction is real, not idle.
  logic [PC_W-1:0] stack_mem [STACK_DEPTH]; // Return address stack.
  logic [STACK_PTR_W-1:0] sp_reg;         // Next free stack level.
  logic [STACK_PTR_W:0] depth_reg;        // Occupied levels, saturating.
  logic wake_meta_reg;                    // Wake-up synchroniser first stage.
  logic wake_sync_reg;                    // Wake-up synchroniser second stage.
  logic cycle_end;                        // Last phase of an instruction cycle.
  logic exec_now;                         // An instruction completes this cycle.
  logic flush;                            // Discard the prefetched word.
  logic [PC_W-1:0] vector;                // Vector of the accepted interrupt.
  logic [PC_W-1:0] ret_addr;              // Address on top of the stack.
  logic push;                             // Call or interrupt push.
  logic pop;                              // Return pop.

  // ****************************************************************
  // Wake-up input synchroniser.
  // ****************************************************************

  // The wake-up request comes from outside the clock domain.
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      wake_meta_reg <= 1'b0;
      wake_sync_reg <= 1'b0;
    end else begin
      wake_meta_reg <= WAKE_UP;
      wake_sync_reg <= wake_meta_reg;
    end
  end

  // ****************************************************************
  // Phases and start-up.
  // ****************************************************************

  // Four phases make one instruction cycle; the phase is frozen while starting up.
  always_ff @(posedge CLOCK) begin
    if (SRST || state_reg == PCSEQ_ST_START) begin
      phase_reg <= PHASE_RESET;
    end else begin
      phase_reg <= phase_reg + 2'h1;
    end
  end

  assign cycle_end = (phase_reg == PHASE_LAST) && (state_reg != PCSEQ_ST_START);

  // Start-up count; a wake-up restarts it so execution is held off again.
  always_ff @(posedge CLOCK) begin
    if (SRST || wake_sync_reg) begin
      startup_reg <= STARTUP_RESET;
    end else if (state_reg == PCSEQ_ST_START) begin
      startup_reg <= startup_reg + 11'h001;
    end
  end

  // State machine: start-up, pipeline fill, then steady run.
  always_ff @(posedge CLOCK) begin
    if (SRST || wake_sync_reg) begin
      state_reg <= PCSEQ_ST_START;
    end else begin
      case (state_reg)
        PCSEQ_ST_START: begin
          if (startup_reg == 11'(STARTUP_CYCLES - 1)) begin
            state_reg <= PCSEQ_ST_FILL;
          end
        end
        PCSEQ_ST_FILL: begin
          if (cycle_end) begin
            state_reg <= PCSEQ_ST_RUN;
          end
        end
        PCSEQ_ST_RUN: begin
          state_reg <= PCSEQ_ST_RUN;
        end
        default: begin
          state_reg <= PCSEQ_ST_START;
        end
      endcase
    end
  end

  // ****************************************************************
  // Counter update.
  // ****************************************************************

  // Only a real instruction at the end of its cycle, or an interrupt accepted there, may alter the flow.
  assign exec_now = cycle_end && exec_valid_reg;
  assign push = cycle_end && (IRQ_ACCEPT || (exec_now && EXEC_CALL));
  assign pop = exec_now && EXEC_RETURN && !IRQ_ACCEPT;
  assign ret_addr = stack_mem[sp_reg - 4'h1];

  // Vector decode; bit 13 is zero in every entry.
  always_comb begin
    case (IRQ_SOURCE)
      PCSEQ_IRQ_EXT0: vector = VEC_EXT0;
      PCSEQ_IRQ_EXT1: vector = VEC_EXT1;
      PCSEQ_IRQ_TMR0: vector = VEC_TMR0;
      PCSEQ_IRQ_TMR1: vector = VEC_TMR1;
      PCSEQ_IRQ_UART: vector = VEC_UART;
      PCSEQ_IRQ_MULTI: vector = VEC_MULTI;
      default: vector = VEC_EXT0;
    endcase
  end

  // Next counter value. The counter already points past the executing word,
  // so plain increment and skip both come down to one more increment here;
  // the skip effect comes from flushing the prefetched word.
  always_comb begin
    pc_next = pc_reg;
    if (cycle_end) begin
      if (IRQ_ACCEPT) begin
        pc_next = vector;
      end else if (exec_now && (EXEC_JUMP || EXEC_CALL)) begin
        pc_next = {BANK_POINTER[BANK_SEL_POS], JUMP_ADDR};
      end else if (exec_now && EXEC_RETURN) begin
        pc_next = ret_addr;
      end else if (exec_now && EXEC_LOW_WRITE) begin
        pc_next = {pc_reg[PC_W-1:8], LOW_WRITE_DATA};
      end else if (exec_now && EXEC_SKIP) begin
        // Stay within the current bank when the step wraps.
        pc_next = {pc_reg[PC_W-1], 13'(pc_reg[PC_W-2:0] + 13'h0001)};
      end else begin
        pc_next = {pc_reg[PC_W-1], 13'(pc_reg[PC_W-2:0] + 13'h0001)};
      end
    end
  end

  // Counter register.
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      pc_reg <= PC_RESET;
    end else if (state_reg == PCSEQ_ST_START) begin
      pc_reg <= pc_reg;
    end else begin
      pc_reg <= pc_next;
    end
  end

  // ****************************************************************
  // Pipeline.
  // ****************************************************************

  // Any flow change replaces the prefetched word with an idle cycle.
  assign flush = IRQ_ACCEPT || (exec_now &&
      (EXEC_JUMP || EXEC_CALL || EXEC_RETURN || EXEC_LOW_WRITE || EXEC_SKIP));

  // The word fetched during this cycle becomes next cycle's instruction.
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      exec_reg <= '0;
      exec_valid_reg <= 1'b0;
    end else if (state_reg == PCSEQ_ST_START) begin
      exec_valid_reg <= 1'b0;
    end else if (cycle_end) begin
      exec_reg <= FETCH_DATA;
      exec_valid_reg <= !flush;
    end
  end

  // ****************************************************************
  // Return stack.
  // ****************************************************************

  // A call pushes the address of the word after the current one, an interrupt that of the first word not executed; when full the
  // oldest entry is overwritten since the pointer simply wraps.
  always_ff @(posedge CLOCK) begin
    if (push) begin
      stack_mem[sp_reg] <= IRQ_ACCEPT ? (exec_valid_reg ? pc_reg - 14'h0001 : pc_reg)
                                      : pc_reg;
    end
  end

  // Stack pointer and occupancy.
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      sp_reg <= '0;
      depth_reg <= '0;
    end else if (push) begin
      sp_reg <= sp_reg + 4'h1;
      if (depth_reg != 5'(STACK_DEPTH)) begin
        depth_reg <= depth_reg + 5'h01;
      end
    end else if (pop) begin
      sp_reg <= sp_reg - 4'h1;
      if (depth_reg != 5'h00) begin
        depth_reg <= depth_reg - 5'h01;
      end
    end
  end

  // ****************************************************************
  // Outputs.
  // ****************************************************************
  assign PROG_ADDR = pc_reg;
  assign UPPER_PROGRAM_BANK = pc_reg[PC_W-1];
  assign PHASE = phase_reg;
  assign CYCLE_END = cycle_end;
  assign EXEC_WORD = exec_reg;
  assign EXEC_VALID = exec_valid_reg;
  assign RUNNING = (state_reg != PCSEQ_ST_START);
  assign COUNTER_LOW_BYTE = pc_reg[7:0];
  assign STACK_FULL = (depth_reg == 5'(STACK_DEPTH));

endmodule // pcseq_top

/* File: tb/pcseq_prog_mem.sv */
// Program memory model that answers the sequencer's fetch address.
module pcseq_prog_mem (
  input wire logic [pcseq_pkg::PC_W-1:0] addr,
  output logic [pcseq_pkg::INSTR_W-1:0] word
);
  // Each word carries its own address, so a fetch from the wrong place shows.
  assign word = {2'h2, addr};
endmodule // pcseq_prog_mem

/* File: tb/pcseq_top_asserts.sv */
// Concurrent checks on the program counter sequencer ports.
module pcseq_top_asserts (
  input wire logic CLOCK,
  input wire logic SRST,
  input wire logic [15:0] FETCH_DATA,
  input wire logic EXEC_JUMP,
  input wire logic EXEC_CALL,
  input wire logic EXEC_RETURN,
  input wire logic EXEC_SKIP,
  input wire logic EXEC_LOW_WRITE,
  input wire logic [7:0] LOW_WRITE_DATA,
  input wire logic [12:0] JUMP_ADDR,
  input wire logic [7:0] BANK_POINTER,
  input wire logic IRQ_ACCEPT,
  input wire pcseq_pkg::pcseq_irq_t IRQ_SOURCE,
  input wire logic [13:0] PROG_ADDR,
  input wire logic UPPER_PROGRAM_BANK,
  input wire logic CYCLE_END,
  input wire logic [15:0] EXEC_WORD,
  input wire logic EXEC_VALID,
  input wire logic RUNNING,
  input wire logic [7:0] COUNTER_LOW_BYTE
);
  // ****************************************************************
  // Properties.
  // ****************************************************************
  default clocking @(posedge CLOCK); endclocking
  default disable iff (SRST);
  // Any decoded flow change; a wake-up restart may break the period spacing.
  wire flow = EXEC_JUMP | EXEC_CALL | EXEC_RETURN | EXEC_SKIP | EXEC_LOW_WRITE;
  wire act = CYCLE_END && EXEC_VALID && !IRQ_ACCEPT;
  property p_period;
    CYCLE_END |=> !CYCLE_END [*3] ##1 (CYCLE_END || !RUNNING);
  endproperty
  a_period: assert property (p_period) else $error("cycle end spacing");
  property p_step;
    CYCLE_END && !IRQ_ACCEPT && !(EXEC_VALID && flow) |=> EXEC_VALID && EXEC_WORD ==
      $past(FETCH_DATA) && PROG_ADDR == {$past(PROG_ADDR[13]), $past(PROG_ADDR[12:0]) + 13'h1};
  endproperty
  a_step: assert property (p_step) else $error("fetch step");
  property p_skip;
    act && EXEC_SKIP |=> !EXEC_VALID && PROG_ADDR[12:0] == $past(PROG_ADDR[12:0]) + 13'h1;
  endproperty
  a_skip: assert property (p_skip) else $error("skip");
  property p_idle;
    act && flow |=> !EXEC_VALID [*4];
  endproperty
  a_idle: assert property (p_idle) else $error("idle cycle");
  property p_jump;
    act && (EXEC_JUMP || EXEC_CALL) |=> PROG_ADDR == {$past(BANK_POINTER[5]), $past(JUMP_ADDR)};
  endproperty
  a_jump: assert property (p_jump) else $error("jump target");
  property p_low;
    act && EXEC_LOW_WRITE |=> PROG_ADDR == {$past(PROG_ADDR[13:8]), $past(LOW_WRITE_DATA)};
  endproperty
  a_low: assert property (p_low) else $error("low byte write");
  property p_vec;
    CYCLE_END && IRQ_ACCEPT |=> PROG_ADDR == {9'h0, $past(IRQ_SOURCE) + 3'h1, 2'h0};
  endproperty
  a_vec: assert property (p_vec) else $error("vector");
  property p_view;
    COUNTER_LOW_BYTE == PROG_ADDR[7:0] && UPPER_PROGRAM_BANK == PROG_ADDR[13];
  endproperty
  a_view: assert property (p_view) else $error("counter view");
  property p_rst;
    $fell(SRST) |-> PROG_ADDR == 14'h0000 && !EXEC_VALID;
  endproperty
  a_rst: assert property (p_rst) else $error("reset state");
endmodule // pcseq_top_asserts
bind pcseq_top pcseq_top_asserts u_pcseq_top_asserts (.CLOCK, .SRST, .FETCH_DATA, .EXEC_JUMP,
  .EXEC_CALL, .EXEC_RETURN, .EXEC_SKIP, .EXEC_LOW_WRITE, .LOW_WRITE_DATA, .JUMP_ADDR,
  .BANK_POINTER, .IRQ_ACCEPT, .IRQ_SOURCE, .PROG_ADDR, .UPPER_PROGRAM_BANK, .CYCLE_END,
  .EXEC_WORD, .EXEC_VALID, .RUNNING, .COUNTER_LOW_BYTE);

/* File: tb/pcseq_top_tb.sv */
// Self-checking bench for the program counter sequencer.
module pcseq_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import pcseq_pkg::*;
  logic clock = 1'b0;
  logic srst = 1'b1;
  logic jump_instruction = 1'b0, call = 1'b0, ret = 1'b0, skip = 1'b0, lw = 1'b0, irq = 1'b0;
  logic [7:0] lw_data = 8'h5a, bp = 8'h00, clb;
  logic [12:0] jaddr = 13'h0000;
  pcseq_irq_t irq_src = PCSEQ_IRQ_EXT0;
  logic [15:0] fdata, ew;
  logic [13:0] pa;
  logic upb, cend, ev, run, sf;
  logic wake = 1'b0;
  logic [1:0] ph;
  int num_errors = 0, check_count = 0;
  // Vector table, one entry per source code.
  logic [13:0] vec [6] = '{14'h004, 14'h008, 14'h00c, 14'h010, 14'h014, 14'h018};
  // A short start-up count keeps the run brief.
  pcseq_top #(.STARTUP_CYCLES(8)) u_pcseq_top (.CLOCK(clock), .SRST(srst), .WAKE_UP(wake),
    .FETCH_DATA(fdata), .EXEC_JUMP(jump_instruction), .EXEC_CALL(call), .EXEC_RETURN(ret),
    .EXEC_SKIP(skip), .EXEC_LOW_WRITE(lw), .LOW_WRITE_DATA(lw_data), .JUMP_ADDR(jaddr),
    .BANK_POINTER(bp), .IRQ_ACCEPT(irq), .IRQ_SOURCE(irq_src), .PROG_ADDR(pa),
    .UPPER_PROGRAM_BANK(upb), .PHASE(ph), .CYCLE_END(cend), .EXEC_WORD(ew),
    .EXEC_VALID(ev), .RUNNING(run), .COUNTER_LOW_BYTE(clb), .STACK_FULL(sf));
  pcseq_prog_mem u_pcseq_prog_mem (.addr(pa), .word(fdata));
  always #2.5 clock = ~clock;
  // ****************************************************************
  // Shared tasks.
  // ****************************************************************
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // Waits, from a falling edge, for a cycle end that executes a real instruction.
  task automatic wait_exec();
    int n;
    n = 0;
    while (!(cend === 1'b1 && ev === 1'b1) && n < 40) begin
      @(negedge clock);
      n++;
    end
    if (n == 40) check(16'h0, 16'h1);
  endtask
  // Decode lines stand for one whole cycle around the taking edge only.
  task automatic issue(input logic [5:0] ctl);
    wait_exec();
    {irq, jump_instruction, call, ret, skip, lw} = ctl;
    @(negedge clock);
    {irq, jump_instruction, call, ret, skip, lw} = 6'h00;
  endtask
  // ****************************************************************
  // Scenarios.
  // ****************************************************************
  task automatic t_startup();
    int n;
    n = 0;
    repeat (8) @(negedge clock);
    srst = 1'b0;
    check(16'(pa), 16'h0000);
    check(16'(ph), 16'h0000);
    while (run !== 1'b1 && n < 50) begin
      @(negedge clock);
      n++;
    end
    check(16'(n), 16'd8);
  endtask
  // Jump into the top of the upper bank, then run across its end.
  task automatic t_jump();
    bp = 8'h20;
    jaddr = 13'h1ffe;
    issue(6'h10);
    check(16'(pa), 16'h3ffe);
    check(16'(upb), 16'h0001);
    check(16'(ev), 16'h0000);
    wait_exec();
    check(ew, 16'hbffe);
    @(negedge clock);
    wait_exec();
    check(16'(pa), 16'h2000);
  endtask
  // A call into the lower bank returns to the upper bank with the bank bit restored from the stack.
  task automatic t_call_ret();
    bp = 8'h00;
    jaddr = 13'h0100;
    issue(6'h08);
    check(16'(pa), 16'h0100);
    issue(6'h04);
    check(16'(pa), 16'h2000);
  endtask
  task automatic t_skip_low();
    issue(6'h02);
    check(16'(pa), 16'h2002);
    check(16'(ev), 16'h0000);
    issue(6'h01);
    check(16'(pa), 16'h205a);
    check(16'(clb), 16'h005a);
  endtask
  // Every source is accepted with the bank bit set; vectors must stay low.
  // Sixteen accepts with no return fill the stack exactly.
  task automatic t_irq();
    bp = 8'h20;
    for (int k = 0; k < 16; k++) begin
      check(16'(sf), 16'h0000);
      irq_src = pcseq_irq_t'(k % 6);
      issue(6'h20);
      check(16'(pa), 16'(vec[k % 6]));
    end
    check(16'(sf), 16'h0001);
  endtask
  // A wake-up request restarts the start-up delay after two synchroniser stages.
  task automatic t_wake();
    int n;
    n = 0;
    wake = 1'b1;
    repeat (3) @(negedge clock);
    check(16'(run), 16'h0000);
    wake = 1'b0;
    while (run !== 1'b1 && n < 50) begin
      @(negedge clock);
      n++;
    end
    check(16'(n), 16'd10);
  endtask
  initial begin
    t_startup();
    t_jump();
    t_call_ret();
    t_skip_low();
    t_irq();
    t_wake();
    give_verdict();
  end
  // The tests need about 1 us; ten times that means a hang.
  initial begin
    #10000;
    num_errors++;
    give_verdict();
  end
endmodule // pcseq_top_tb
